// ### hdl/rxcmd_pkg.sv
package rxcmd_pkg;
  // status byte field positions
  localparam int LS_LSB = 0;
  localparam int VB_LSB = 2;
  localparam int EV_LSB = 4;
  localparam int ID_BIT = 6;
  localparam int ALT_BIT = 7;
  // encoded vbus levels
  localparam logic [1:0] VB_BELOW_END = 2'h0;
  localparam logic [1:0] VB_END_SESS = 2'h1;
  localparam logic [1:0] VB_SESS_VLD = 2'h2;
  localparam logic [1:0] VB_ABOVE_VLD = 2'h3;
  // encoded receive events
  localparam logic [1:0] EV_IDLE = 2'h0;
  localparam logic [1:0] EV_RX_OK = 2'h1;
  localparam logic [1:0] EV_DISCON = 2'h2;
  localparam logic [1:0] EV_RX_ERR = 2'h3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TURN = 2'b01,
    ST_SEND = 2'b11,
    ST_DONE = 2'b10
  } send_state_t;
endpackage

// ### hdl/rxcmd_byte.sv
`timescale 1ns/100ps
// builds the status byte from synchronised status levels and unsynchronised receive event inputs
module rxcmd_byte
  import rxcmd_pkg::*;
(
  input wire logic [1:0] line_i,
  input wire logic sess_end_i,
  input wire logic sess_vld_i,
  input wire logic vbus_vld_i,
  input wire logic rx_active_i,
  input wire logic rx_error_i,
  input wire logic host_discon_i,
  input wire logic id_i,
  input wire logic alt_int_i,
  output logic [7:0] byte_o
);
  wire [1:0] vb_code;
  wire [1:0] ev_code;
  assign vb_code = vbus_vld_i ? VB_ABOVE_VLD :
                   sess_vld_i ? VB_SESS_VLD :
                   sess_end_i ? VB_BELOW_END : VB_END_SESS;
  assign ev_code = host_discon_i ? EV_DISCON :
                   !rx_active_i ? EV_IDLE :
                   rx_error_i ? EV_RX_ERR : EV_RX_OK;
  always_comb
  begin
    byte_o = 8'h00;
    byte_o[LS_LSB +: 2] = line_i;
    byte_o[VB_LSB +: 2] = vb_code;
    byte_o[EV_LSB +: 2] = ev_code;
    byte_o[ID_BIT] = id_i;
    byte_o[ALT_BIT] = alt_int_i;
  end
endmodule

// ### hdl/rxcmd_gen.sv
`timescale 1ns/100ps
// Operation
// - Status bytes go out only in synchronous mode while dir is high.
// - A line state change with dir low sends a status byte at once.
// - During receive, a status byte is driven whenever dir=1, nxt=0.
// - During transmit status bytes wait until stop, then are sent.
// - A change of the vbus or id comparator outputs sends a status byte.
// - After start-up, dir dropped with stop low, a status byte is sent.
// - The link raises stop to leave a special mode; a byte follows.
// - Byte bits 1:0 carry the full-speed line state.
// - Line bit 0 follows the positive line, bit 1 the negative line.
// - Bits 3:2 encode the vbus level in four bands.
// - Bits 5:4 at 00 mean no receive, no error, no disconnect.
// - Bit 6 mirrors the id pin.
// - Bit 7 flags an unmasked carkit interrupt; the link reads the latch.
module rxcmd_gen
  import rxcmd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic SYNC_MODE_I,
  input wire logic STARTUP_I,
  input wire logic TX_ACTIVE_I,
  input wire logic SPECIAL_MODE_I,
  input wire logic STP_I,
  input wire logic DP_I,
  input wire logic DM_I,
  input wire logic SESS_END_I,
  input wire logic SESS_VLD_I,
  input wire logic VBUS_VLD_I,
  input wire logic ID_I,
  input wire logic RX_ACTIVE_I,
  input wire logic RX_ERROR_I,
  input wire logic HOST_DISCON_I,
  input wire logic ALT_INT_I,
  input wire logic RX_NXT_I,
  input wire logic RX_DIR_I,
  output logic DIR_O,
  output logic DATA_OE_O,
  output logic [7:0] DATA_O,
  output logic PENDING_O
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only the second stage is read
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] meta_ff, sync_ff, prev_ff;
  wire [NSYNC-1:0] raw_in;
  assign raw_in = {ALT_INT_I, ID_I, VBUS_VLD_I, SESS_VLD_I,
                   SESS_END_I, DM_I} ;
  logic dp_meta_ff, dp_ff;
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      dp_meta_ff <= 1'b0;
      dp_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
      dp_meta_ff <= DP_I;
      dp_ff <= dp_meta_ff;
    end
  end
  wire [1:0] line_now;
  wire [1:0] line_prev;
  assign line_now = {sync_ff[0], dp_ff};
  assign line_prev = {prev_ff[0], prev_ff[5]};
  wire [3:0] cmp4_now = {sync_ff[4], sync_ff[3], sync_ff[2], sync_ff[1]};
  wire [3:0] cmp4_prev = {prev_ff[4], prev_ff[3], prev_ff[2], prev_ff[1]};
  ////////////////////////////////////////////////////////////////////////
  // event sources
  // change detectors stay blind until the synchronisers hold real pins
  localparam int WARM = 3;
  logic [WARM-1:0] warm_ff;
  logic stp_d_ff, spec_d_ff, boot_ff;
  wire armed = warm_ff[WARM-1];
  wire line_chg = (line_now != line_prev) && armed;
  wire cmp_chg = (cmp4_now != cmp4_prev) && armed;
  wire stp_rise = STP_I && !stp_d_ff;
  wire tx_end = TX_ACTIVE_I && stp_rise;
  wire mode_exit = spec_d_ff && !SPECIAL_MODE_I && stp_d_ff;
  wire start_evt = STARTUP_I && !boot_ff && !RX_DIR_I && !STP_I;
  wire rx_slot = RX_ACTIVE_I && RX_DIR_I && !RX_NXT_I;
  wire hold_tx = TX_ACTIVE_I && !STP_I;
  wire new_evt = line_chg || cmp_chg || tx_end || mode_exit || start_evt;
  logic pend_ff;
  send_state_t st_ff, nxt_st;
  wire can_go = SYNC_MODE_I && !hold_tx && !RX_DIR_I;
  // a send slot lost to a mode drop keeps the byte queued
  wire sent = (st_ff == ST_SEND) && oe_ff;
  // set beats the clear in the sending cycle
  wire nxt_pend = new_evt || (pend_ff && !sent);
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: if (pend_ff && can_go) nxt_st = ST_TURN;
      ST_TURN: nxt_st = ST_SEND;
      ST_SEND: nxt_st = ST_DONE;
      ST_DONE: nxt_st = ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      prev_ff <= '0;
      warm_ff <= '0;
      stp_d_ff <= 1'b0;
      spec_d_ff <= 1'b0;
      boot_ff <= 1'b0;
      pend_ff <= 1'b0;
      st_ff <= ST_IDLE;
    end
    else if (CE_I)
    begin
      prev_ff <= {dp_ff, sync_ff[4:0]};
      warm_ff <= {warm_ff[WARM-2:0], 1'b1};
      stp_d_ff <= STP_I;
      spec_d_ff <= SPECIAL_MODE_I;
      boot_ff <= STARTUP_I && (boot_ff || start_evt);
      pend_ff <= nxt_pend;
      st_ff <= nxt_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // byte build and bus drive
  logic [7:0] status_byte;
  rxcmd_byte u_byte (
    .line_i(line_now),
    .sess_end_i(sync_ff[1]),
    .sess_vld_i(sync_ff[2]),
    .vbus_vld_i(sync_ff[3]),
    .rx_active_i(RX_ACTIVE_I),
    .rx_error_i(RX_ERROR_I),
    .host_discon_i(HOST_DISCON_I),
    .id_i(sync_ff[4]),
    .alt_int_i(sync_ff[5]),
    .byte_o(status_byte)
  );
  logic [7:0] data_ff;
  logic oe_ff;
  wire drive_now = SYNC_MODE_I && ((nxt_st == ST_SEND) || rx_slot);
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      data_ff <= BYTE_RESET;
      oe_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      data_ff <= drive_now ? status_byte : IDLE_BYTE;
      oe_ff <= drive_now;
    end
  end
  assign DATA_O = data_ff;
  assign DATA_OE_O = oe_ff;
  assign DIR_O = (st_ff != ST_IDLE);
  assign PENDING_O = pend_ff;
  ////////////////////////////////////////////////////////////////////////
  property p_sync_only;
    @(posedge CLK_I) disable iff (!NRST_I)
    (oe_ff && $past(CE_I)) |-> $past(SYNC_MODE_I);
  endproperty
  a_sync_only: assert property (p_sync_only)
    else $error("status byte outside sync mode");
  property p_line_send;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && line_chg && st_ff == ST_IDLE && can_go && !pend_ff)
      |=> pend_ff;
  endproperty
  a_line_send: assert property (p_line_send)
    else $error("line change not queued");
  property p_rx_slot;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && rx_slot && SYNC_MODE_I) |=> oe_ff;
  endproperty
  a_rx_slot: assert property (p_rx_slot)
    else $error("receive slot missed");
  property p_tx_hold;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && st_ff == ST_IDLE && hold_tx) |=> st_ff == ST_IDLE;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("sent during transmit");
  property p_cmp;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && cmp_chg) |=> pend_ff;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("comparator change lost");
  property p_walk;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && st_ff == ST_IDLE && nxt_st == ST_TURN)
      |=> DIR_O ##0 (!CE_I || st_ff == ST_TURN);
  endproperty
  a_walk: assert property (p_walk)
    else $error("send walk broken");
  property p_ls;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && drive_now) |=> DATA_O[1:0] == $past(line_now);
  endproperty
  a_ls: assert property (p_ls)
    else $error("line state field wrong");
  property p_id;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && drive_now) |=> DATA_O[ID_BIT] == $past(sync_ff[4]);
  endproperty
  a_id: assert property (p_id)
    else $error("id field wrong");
  property p_vb;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && drive_now && sync_ff[3])
      |=> DATA_O[VB_LSB +: 2] == VB_ABOVE_VLD;
  endproperty
  a_vb: assert property (p_vb)
    else $error("vbus field wrong");
  property p_discon;
    @(posedge CLK_I) disable iff (!NRST_I)
    (CE_I && drive_now && HOST_DISCON_I)
      |=> DATA_O[EV_LSB +: 2] == EV_DISCON;
  endproperty
  a_discon: assert property (p_discon)
    else $error("disconnect code wrong");
  c_send: cover property (@(posedge CLK_I) st_ff == ST_SEND);
  c_start: cover property (@(posedge CLK_I) start_evt);
  c_rx: cover property (@(posedge CLK_I) rx_slot);
  c_txend: cover property (@(posedge CLK_I) tx_end);
endmodule

// ### verification/link_model.sv
`timescale 1ns/100ps
// far-side link: drives stop, captures every status byte on the bus
module link_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic dir_i,
  input wire logic oe_i,
  input wire logic [7:0] data_i,
  input wire logic stp_req_i,
  output logic stp_o,
  output logic [7:0] last_o,
  output int cnt_o
);
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      stp_o <= 1'b0;
      last_o <= 8'h00;
      cnt_o <= 0;
    end
    else
    begin
      stp_o <= stp_req_i;
      if (dir_i && oe_i)
      begin
        last_o <= data_i;
        cnt_o <= cnt_o + 1;
      end
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
  import rxcmd_pkg::*;
  logic clk, nrst, dp, dm, id, alt, ra, re, hd, nxt, rdir, sync, tx, sreq;
  logic spec, startup, ce;
  logic [1:0] vb;
  logic dir, oe, pend, stp;
  logic [7:0] data, last;
  int cnt, err_count, n_checks, seed, i;
  rxcmd_gen rxcmd_gen_inst (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .SYNC_MODE_I(sync), .STARTUP_I(startup), .TX_ACTIVE_I(tx),
    .SPECIAL_MODE_I(spec), .STP_I(stp), .DP_I(dp), .DM_I(dm),
    .SESS_END_I(vb == 2'h0), .SESS_VLD_I(vb[1]), .VBUS_VLD_I(vb == 2'h3),
    .ID_I(id), .RX_ACTIVE_I(ra), .RX_ERROR_I(re), .HOST_DISCON_I(hd),
    .ALT_INT_I(alt), .RX_NXT_I(nxt), .RX_DIR_I(rdir), .DIR_O(dir),
    .DATA_OE_O(oe), .DATA_O(data), .PENDING_O(pend));
  link_model link_model_inst (.clk_i(clk), .nrst_i(nrst),
    .dir_i(dir | rdir), .oe_i(oe),
    .data_i(data), .stp_req_i(sreq), .stp_o(stp), .last_o(last),
    .cnt_o(cnt));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] exp_b();
    logic [1:0] ev;
    ev = hd ? EV_DISCON : (ra ? (re ? EV_RX_ERR : EV_RX_OK) : EV_IDLE);
    return {alt, id, ev, vb, dm, dp};
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wait_byte();
    int c0;
    c0 = cnt;
    for (int k = 0; k < 40 && cnt == c0; k++)
      step(1);
    chk_bit(cnt != c0, 1'b1);
    chk_byte(last, exp_b());
  endtask
  task automatic no_byte();
    int c0;
    c0 = cnt;
    step(15);
    chk_bit(cnt == c0, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(50 * 5000);
    err_count++;
    stop_test();
  end
  initial
  begin
    {dp, dm, id, alt, ra, re, hd, nxt, rdir, tx, sreq} = 11'h000;
    {spec, startup, ce} = 3'h1;
    vb = 2'h0;
    sync = 1'b1;
    nrst = 1'b0;
    err_count = 0;
    n_checks = 0;
    seed = 32'h2ea6cd62;
    step(12);
    nrst = 1'b1;
    step(30);
    for (i = 0; i < 10; i++)
    begin
      dp = ~dp;
      {dm, id, alt, vb} = 5'($random(seed));
      wait_byte();
    end
    $display("test 1 done");
    {rdir, nxt} = 2'h2;
    for (i = 0; i < 4; i++)
    begin
      {hd, re, ra} = {i[1], i[0], 1'b1};
      step(3);
      wait_byte();
    end
    {rdir, ra, re, hd} = 4'h0;
    step(10);
    $display("test 2 done");
    tx = 1'b1;
    dp = ~dp;
    no_byte();
    chk_bit(pend, 1'b1);
    sreq = 1'b1;
    wait_byte();
    {sreq, tx} = 2'h0;
    $display("test 3 done");
    step(5);
    sync = 1'b0;
    dm = ~dm;
    no_byte();
    chk_bit(dir, 1'b0);
    sync = 1'b1;
    wait_byte();
    $display("test 4 done");
    startup = 1'b1;
    rdir = 1'b1;
    step(3);
    rdir = 1'b0;
    wait_byte();
    no_byte();
    startup = 1'b0;
    $display("test 5 done");
    {spec, sreq} = 2'h3;
    step(2);
    {spec, sreq} = 2'h0;
    wait_byte();
    ce = 1'b0;
    dp = ~dp;
    no_byte();
    ce = 1'b1;
    wait_byte();
    $display("test 6 done");
    stop_test();
  end
endmodule
